/* File: hdl/wic_top.sv */
// Module: wake-up and interrupt dispatch between event sources and CPU
`timescale 1ns/100ps
`default_nettype none
module wic_top
  import wic_pkg::*;
(
  input  wire logic       I_CORE_CLK,
  input  wire logic       I_RST,
  input  wire logic       i_ext_irq_pin_a,
  input  wire logic       i_ext_irq_pin_b,
  input  wire logic       i_pinchg_evt,
  input  wire logic       i_timer_ovf_evt,
  input  wire logic       i_cmp_evt,
  input  wire logic       i_wdt_timeout,
  input  wire logic       i_low_volt,
  input  wire logic [7:0] i_irq_en,
  input  wire logic [7:0] i_wake_en,
  input  wire logic [7:0] i_wdt_ctrl,
  input  wire logic [7:0] i_cmp_ctrl,
  input  wire logic       i_global_irq_on_instr,
  input  wire logic       i_global_irq_off_instr,
  input  wire logic       i_sleep_instr,
  input  wire logic [4:0] i_pend_clr,
  output logic            O_SLEEP,
  output logic            O_CLK_RUN,
  output logic [1:0]      O_ACT,
  output logic [7:0]      O_VECTOR,
  output logic [4:0]      O_PEND,
  output logic            O_GIE,
  output logic            O_TO_FLAG,
  output logic            O_PD_FLAG
);

  // Two-stage synchronisers for pins and asynchronous events
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [6:0] prev;
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
      prev  <= 7'h00;
    end else begin
      sync1 <= {i_low_volt, i_wdt_timeout, i_cmp_evt, i_timer_ovf_evt,
                i_pinchg_evt, i_ext_irq_pin_b, i_ext_irq_pin_a};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // Rising edges of synchronised lines are the events
  wire [6:0] edge_w = sync2 & ~prev;
  wire ev_exta = edge_w[0];
  wire ev_extb = edge_w[1];
  wire ev_pc   = edge_w[2];
  wire ev_tmr  = edge_w[3];
  wire ev_cmp  = edge_w[4];
  wire ev_wdt  = edge_w[5];
  wire ev_lvr  = edge_w[6];

  wic_state_t state;
  logic       gie;
  logic       wdt_at_sleep;
  wic_pend_t  pend;
  wire asleep = (state == WIC_ST_SLEEP);

  // Enable decode
  wire en_ext  = i_irq_en[BIT_EXT_IE];
  wire en_pci  = i_irq_en[BIT_PINCHG_IE];
  wire en_tmr  = i_irq_en[BIT_TIMER_IE];
  wire en_cmpi = i_cmp_ctrl[BIT_CMP_IE];
  wire en_wdt  = i_wdt_ctrl[BIT_WDT_EN];
  // Watchdog running at sleep entry masks the pin change and comparator wakes
  wire en_pcw  = i_wake_en[BIT_PINCHG_WE] & ~wdt_at_sleep;
  wire en_cmpw = i_wake_en[BIT_CMP_WE] & ~wdt_at_sleep;

  // Flag set terms; in sleep the timer is frozen and the ext pins are dead
  wire set_exta = ev_exta & en_ext & ~asleep;
  wire set_extb = ev_extb & en_ext & ~asleep;
  wire set_pc   = ev_pc & en_pci;
  wire set_tmr  = ev_tmr & en_tmr & ~asleep;
  wire set_cmp  = ev_cmp & en_cmpi;

  // Reset sources
  wire do_reset = (ev_wdt & en_wdt) | ev_lvr;

  // Wake terms: only permitted sources end sleep
  wire wake_pc  = asleep & ev_pc & en_pcw;
  wire wake_cmp = asleep & ev_cmp & en_cmpw;
  wire wake_any = wake_pc | wake_cmp;

  // Dispatch: an enabled irq event while running or waking vectors with GIE, else next
  wire irq_run  = ~asleep & (set_exta | set_extb | set_pc | set_tmr
                  | set_cmp);
  wire irq_wake = (wake_pc & en_pci) | (wake_cmp & en_cmpi);
  wire go_irq   = irq_run | irq_wake;
  wic_act_t next_act;
  assign next_act = do_reset ? WIC_ACT_RESET :
                    (go_irq & gie) ? WIC_ACT_VEC :
                    (go_irq | wake_any) ? WIC_ACT_NEXT :
                    WIC_ACT_NONE;
  wire [7:0] next_vec = (next_act == WIC_ACT_RESET) ? VEC_RESET : VEC_IRQ;

  // Power state and global enable
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      state        <= WIC_ST_RUN;
      gie          <= 1'b0;
      wdt_at_sleep <= 1'b0;
    end else begin
      if (do_reset || wake_any) begin
        state <= WIC_ST_RUN;
      end else if (i_sleep_instr && !asleep) begin
        state        <= WIC_ST_SLEEP;
        wdt_at_sleep <= en_wdt;
      end
      if (do_reset) begin
        gie <= 1'b0;
      end else if (i_global_irq_on_instr) begin
        gie <= 1'b1;
      end else if (i_global_irq_off_instr) begin
        gie <= 1'b0;
      end
    end
  end

  // Sticky pending flags; a set in the clear cycle wins
  wire [4:0] set_vec = {set_exta, set_extb, set_pc, set_tmr, set_cmp};
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      pend <= PEND_RST;
    end else begin
      pend <= (pend & ~i_pend_clr) | set_vec;
    end
  end

  // Time-out and power-down status survive the reset-type wake
  logic to_flag;
  logic pd_flag;
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      to_flag <= 1'b0;
      pd_flag <= 1'b0;
    end else begin
      if (do_reset) begin
        to_flag <= ev_wdt & en_wdt;
        pd_flag <= asleep;
      end else if (i_sleep_instr && !asleep) begin
        pd_flag <= 1'b1;
      end
    end
  end

  // Registered outputs to the CPU sequencer
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_ACT    <= WIC_ACT_NONE;
      O_VECTOR <= VEC_RESET;
      O_SLEEP  <= 1'b0;
      O_CLK_RUN <= 1'b1;
    end else begin
      O_ACT    <= next_act;
      O_VECTOR <= next_vec;
      O_SLEEP  <= asleep & ~wake_any & ~do_reset;
      // Clock stays gated until a permitted wake source or a reset
      O_CLK_RUN <= ~(asleep & ~wake_any & ~do_reset);
    end
  end
  assign O_PEND    = pend;
  assign O_GIE     = gie;
  assign O_TO_FLAG = to_flag;
  assign O_PD_FLAG = pd_flag;

  // Checks: each looks one edge after the detected event, where the
  // registered outputs and flags have settled

  // External pin events flag only while running
  AST_EXT_FLAG: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    ev_exta && en_ext && !asleep |=> pend.ext_pin0_pending)
    else $error("ext pin a flag not set");
  // Second external pin has its own flag
  AST_EXTB_FLAG: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    ev_extb && en_ext && !asleep |=> pend.ext_pin1_pending)
    else $error("ext pin b flag not set");
  // External pins are dead in sleep
  AST_EXT_SLEEP: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    asleep && ev_exta && !pend.ext_pin0_pending
    |=> !pend.ext_pin0_pending)
    else $error("ext pin flagged in sleep");

  // Pin change with both enables clear causes no dispatch
  AST_PC_IGNORE: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    ev_pc && !en_pci && !i_wake_en[BIT_PINCHG_WE] && !ev_cmp && !ev_exta
    && !ev_extb && !ev_tmr && !do_reset |=> O_ACT == WIC_ACT_NONE)
    else $error("ignored pin change dispatched");
  // Pin change without wake enable keeps the device asleep
  AST_PC_NO_WAKE: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    asleep && ev_pc && !i_wake_en[BIT_PINCHG_WE] && !ev_cmp && !do_reset
    |=> asleep)
    else $error("pin change woke without enable");
  // Enabled pin change always flags
  AST_PC_FLAG: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    ev_pc && en_pci |=> pend.pinchg_pending)
    else $error("pin change flag not set");
  // Flag only: stays asleep with no dispatch
  AST_PC_STAY: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    asleep && ev_pc && en_pci && !en_pcw && !ev_cmp && !do_reset
    |=> asleep && O_ACT == WIC_ACT_NONE)
    else $error("pin change left sleep");
  // Wake enable ends sleep with a dispatch
  AST_PC_WAKE: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    wake_pc && !do_reset |=> !asleep && O_ACT != WIC_ACT_NONE)
    else $error("pin change wake missing");
  // Wake only leaves the flag alone
  AST_PC_NO_FLAG: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    ev_pc && !en_pci && !pend.pinchg_pending |=> !pend.pinchg_pending)
    else $error("pin change flag without enable");
  // Wake with interrupts off continues in order
  AST_PC_NEXT: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    wake_pc && !gie && !do_reset |=> O_ACT == WIC_ACT_NEXT)
    else $error("pin change wake not next");
  // Enabled request with interrupts on vectors
  AST_VEC: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    go_irq && gie && !do_reset
    |=> O_ACT == WIC_ACT_VEC && O_VECTOR == VEC_IRQ)
    else $error("vector not taken");
  // Running request with interrupts off continues in order
  AST_RUN_NEXT: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    irq_run && !gie && !do_reset |=> O_ACT == WIC_ACT_NEXT)
    else $error("running request not next");

  // Timer never ends sleep
  AST_TMR_NO_WAKE: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    asleep && ev_tmr && !ev_pc && !ev_cmp && !do_reset |=> asleep)
    else $error("timer woke device");
  // Timer flags while running
  AST_TMR_FLAG: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    ev_tmr && en_tmr && !asleep |=> pend.timer_ovf_pending)
    else $error("timer flag not set");

  // Comparator without its irq enable leaves the flag clear
  AST_CMP_IGN: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    ev_cmp && !en_cmpi && !pend.comparator_pending
    |=> !pend.comparator_pending)
    else $error("comparator flag without enable");
  // Comparator without wake enable keeps the device asleep
  AST_CMP_NO_WAKE: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    asleep && ev_cmp && !i_wake_en[BIT_CMP_WE] && !ev_pc && !do_reset
    |=> asleep)
    else $error("comparator woke without enable");
  // Flag only: comparator flags and the device sleeps on
  AST_CMP_STAY: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    asleep && ev_cmp && en_cmpi && !en_cmpw && !ev_pc && !do_reset
    |=> asleep && pend.comparator_pending)
    else $error("comparator flag-only case wrong");
  // Comparator wake ends sleep with a dispatch
  AST_CMP_WAKE: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    wake_cmp && !do_reset |=> !asleep && O_ACT != WIC_ACT_NONE)
    else $error("comparator wake missing");
  // Comparator wake with irq on, interrupts off: flag and next
  AST_CMP_NEXT: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    wake_cmp && en_cmpi && !gie && !do_reset
    |=> O_ACT == WIC_ACT_NEXT && pend.comparator_pending)
    else $error("comparator wake not next");
  // Comparator with interrupts on vectors when it may act
  AST_CMP_VEC: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    ev_cmp && en_cmpi && gie && !do_reset && (!asleep || en_cmpw)
    |=> O_ACT == WIC_ACT_VEC)
    else $error("comparator vector missing");
  // Running comparator with interrupts off: flag and next
  AST_CMP_RUN: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    !asleep && ev_cmp && en_cmpi && !gie && !do_reset
    |=> O_ACT == WIC_ACT_NEXT && pend.comparator_pending)
    else $error("running comparator not next");

  // Reset sources restart at address zero
  AST_RESET: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    do_reset |=> O_ACT == WIC_ACT_RESET && O_VECTOR == VEC_RESET)
    else $error("reset dispatch wrong");
  // A reset wakes the device and restarts the clock
  AST_RESET_WAKE: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    do_reset |=> !asleep && O_CLK_RUN && !O_SLEEP)
    else $error("reset did not wake");
  // Clock held while nothing permitted wakes
  AST_CLK_STOP: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    asleep && !wake_any && !do_reset |=> !O_CLK_RUN && O_SLEEP)
    else $error("clock ran in sleep");
  // Watchdog at sleep entry blocks every pin wake
  AST_WDT_MASK: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    asleep && wdt_at_sleep && !do_reset |=> asleep)
    else $error("pin wake with watchdog");
  // Power-down flag survives a reset out of sleep
  AST_PD_KEPT: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    do_reset && asleep |=> O_PD_FLAG)
    else $error("power-down flag lost");
  // Time-out flag marks a watchdog reset
  AST_TO_SET: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    ev_wdt && en_wdt |=> O_TO_FLAG)
    else $error("time-out flag not set");

  // Flags hold until their own clear
  AST_STICKY: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    pend.timer_ovf_pending && !i_pend_clr[1] |=> pend.timer_ovf_pending)
    else $error("flag lost");
  // A set in the clear cycle wins
  AST_SET_WINS: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    set_pc && i_pend_clr[2] |=> pend.pinchg_pending)
    else $error("clear beat a set");
  // A clear with no set drops the flag
  AST_CLR: assert property (
    @(posedge I_CORE_CLK) disable iff (I_RST)
    i_pend_clr[2] && !set_pc |=> !pend.pinchg_pending)
    else $error("flag not cleared");

  // Main scenarios reached
  COV_PC_WAKE: cover property (@(posedge I_CORE_CLK) wake_pc && gie);
  COV_CMP_WAKE: cover property (@(posedge I_CORE_CLK) wake_cmp);
  COV_WDT: cover property (@(posedge I_CORE_CLK) do_reset && asleep);
  COV_RUN_IRQ: cover property (@(posedge I_CORE_CLK) irq_run && !gie);
  COV_FLAG_ONLY: cover property (@(posedge I_CORE_CLK)
    asleep && set_cmp && !wake_any);

endmodule // wic_top
`default_nettype wire

/* File: hdl/wic_pkg.sv */
// Package: constants and types for the wake and interrupt control block
package wic_pkg;

  localparam logic [7:0] VEC_RESET = 8'h00;
  localparam logic [7:0] VEC_IRQ   = 8'h08;
  // Enable bit positions inside the enable bytes
  localparam int BIT_TIMER_IE  = 0;
  localparam int BIT_PINCHG_IE = 1;
  localparam int BIT_EXT_IE    = 2;
  localparam int BIT_CMP_IE    = 0;
  localparam int BIT_CMP_WE    = 2;
  localparam int BIT_PINCHG_WE = 4;
  localparam int BIT_WDT_EN    = 7;
  localparam logic [4:0] PEND_RST = 5'h00;

  // CPU sequencer actions
  typedef enum logic [1:0] {
    WIC_ACT_NONE  = 2'b00,
    WIC_ACT_NEXT  = 2'b01,
    WIC_ACT_VEC   = 2'b10,
    WIC_ACT_RESET = 2'b11
  } wic_act_t;

  // Power states
  typedef enum logic [0:0] {
    WIC_ST_RUN   = 1'b0,
    WIC_ST_SLEEP = 1'b1
  } wic_state_t;

  // Pending flags of all interrupt sources
  typedef struct packed {
    logic ext_pin0_pending;
    logic ext_pin1_pending;
    logic pinchg_pending;
    logic timer_ovf_pending;
    logic comparator_pending;
  } wic_pend_t;

endpackage

/* File: sim/wic_cpu_model.sv */
// Partner model: CPU sequencer issuing instructions and taking dispatches
`timescale 1ns/100ps
`default_nettype none
module wic_cpu_model
  import wic_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_act,
  input  wire logic [7:0] i_vector,
  output logic            o_irq_on,
  output logic            o_irq_off,
  output logic            o_sleep,
  output logic [4:0]      o_clr,
  output logic [1:0]      o_last_act,
  output logic [7:0]      o_last_vec
);
  initial {o_irq_on, o_irq_off, o_sleep, o_clr} = 8'h00;

  // One-cycle instruction strobe {on, off, sleep, clear[4:0]}
  task automatic pulse(input logic [7:0] what);
    @(negedge i_clk);
    {o_irq_on, o_irq_off, o_sleep, o_clr} = what;
    @(negedge i_clk);
    {o_irq_on, o_irq_off, o_sleep, o_clr} = 8'h00;
  endtask

  // Latch the last dispatch, since the action only stands for one cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_last_act <= 2'h0;
      o_last_vec <= 8'hFF;
    end else if (i_act != WIC_ACT_NONE) begin
      o_last_act <= i_act;
      o_last_vec <= i_vector;
    end
  end
endmodule // wic_cpu_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Testbench: event table and corner cases for the wake and interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import wic_pkg::*;
;
  typedef struct packed {
    logic       slp, gie, wd, cie;
    logic [7:0] ie, we;
    logic [2:0] ev;
    logic [1:0] act;
    logic [4:0] pend;
  } wic_row_t;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [6:0] ev  = 7'h00;
  logic [7:0] ie  = 8'h00, we = 8'h00, wd = 8'h00, cc = 8'h00;
  logic       on, off, slp, sleeping, clk_run, gie, to_f, pd_f;
  logic [4:0] clr, pend;
  logic [1:0] act, last_act;
  logic [7:0] vec, last_vec;
  int         fails = 0, tests_run = 0, cyc = 0;

  // Events: 0 pin a, 1 pin b, 2 pin change, 3 timer, 4 cmp, 5 wdt, 6 lv
  wic_row_t rows [19] = '{
    '{0,0,0,0,'h04,'h00,0,1,'h10},
    '{0,1,0,0,'h04,'h00,1,2,'h08},
    '{1,0,0,0,'h00,'h00,2,0,'h00},
    '{0,1,0,0,'h00,'h00,2,0,'h00},
    '{1,1,0,0,'h02,'h00,2,0,'h04},
    '{1,0,0,0,'h00,'h10,2,1,'h00},
    '{1,0,0,0,'h02,'h10,2,1,'h04},
    '{1,1,0,0,'h02,'h10,2,2,'h04},
    '{0,1,0,0,'h02,'h00,2,2,'h04},
    '{1,1,0,0,'h01,'h00,3,0,'h00},
    '{0,0,0,0,'h01,'h00,3,1,'h02},
    '{1,1,0,0,'h00,'h00,4,0,'h00},
    '{1,0,0,1,'h00,'h00,4,0,'h01},
    '{1,0,0,0,'h00,'h04,4,1,'h00},
    '{1,0,0,1,'h00,'h04,4,1,'h01},
    '{1,1,0,1,'h00,'h04,4,2,'h01},
    '{0,0,0,1,'h00,'h00,4,1,'h01},
    '{1,0,1,0,'h00,'h00,5,3,'h00},
    '{1,1,0,0,'h00,'h00,6,3,'h00}
  };

  wic_top uut (
    .I_CORE_CLK(clk), .I_RST(rst), .i_ext_irq_pin_a(ev[0]),
    .i_ext_irq_pin_b(ev[1]), .i_pinchg_evt(ev[2]),
    .i_timer_ovf_evt(ev[3]), .i_cmp_evt(ev[4]), .i_wdt_timeout(ev[5]),
    .i_low_volt(ev[6]), .i_irq_en(ie), .i_wake_en(we), .i_wdt_ctrl(wd),
    .i_cmp_ctrl(cc), .i_global_irq_on_instr(on),
    .i_global_irq_off_instr(off), .i_sleep_instr(slp), .i_pend_clr(clr),
    .O_SLEEP(sleeping), .O_CLK_RUN(clk_run), .O_ACT(act), .O_VECTOR(vec),
    .O_PEND(pend), .O_GIE(gie), .O_TO_FLAG(to_f), .O_PD_FLAG(pd_f));

  wic_cpu_model cpu (
    .i_clk(clk), .i_rst(rst), .i_act(act), .i_vector(vec),
    .o_irq_on(on), .o_irq_off(off), .o_sleep(slp), .o_clr(clr),
    .o_last_act(last_act), .o_last_vec(last_vec));

  always #25 clk = ~clk;

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Rising edge held two cycles, then wait out sync and dispatch
  task automatic fire(input int idx);
    @(negedge clk);
    ev[idx] = 1'b1;
    cyc_n(2);
    ev = 7'h00;
    cyc_n(6);
  endtask

  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    cyc_n(2);
    rst = 1'b0;
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    cyc_n(8);
    rst = 1'b0;
    chk({4'h0, act, pend, gie, sleeping, clk_run, to_f, pd_f}, 16'h0004);
    foreach (rows[k]) begin
      do_reset();
      ie = rows[k].ie;
      we = rows[k].we;
      wd = {rows[k].wd, 7'h00};
      cc = {7'h00, rows[k].cie};
      cpu.pulse(rows[k].gie ? 8'h80 : 8'h40);
      if (rows[k].slp)
        cpu.pulse(8'h20);
      cyc_n(2);
      fire(rows[k].ev);
      chk({7'h00, last_act, pend, sleeping, clk_run},
          {7'h00, rows[k].act, rows[k].pend,
           rows[k].slp && rows[k].act == 2'h0,
           !(rows[k].slp && rows[k].act == 2'h0)});
      if (rows[k].act[1])
        chk({8'h00, last_vec}, {8'h00, rows[k].act[0] ? VEC_RESET : VEC_IRQ});
    end
    // Sticky flags, and clearing one leaves the other
    do_reset();
    ie = 8'h03;
    fire(2);
    fire(3);
    chk({11'h000, pend}, 16'h0006);
    cpu.pulse(8'h04);
    cyc_n(2);
    chk({11'h000, pend}, 16'h0002);
    // Watchdog on at sleep entry blocks the pin-change wake
    do_reset();
    we = 8'h10;
    wd = 8'h80;
    cpu.pulse(8'h20);
    cyc_n(2);
    fire(2);
    chk({13'h0000, last_act, sleeping}, 16'h0001);
    fire(5);
    chk({3'h0, last_act, last_vec, sleeping, to_f, pd_f}, 16'h1803);
    close_out();
  end
endmodule // tb_top
`default_nettype wire
